// *** cfpf_partner.sv ***
`timescale 1ns/1ps
// ****
// Producer and consumer model
// ****
module cfpf_partner
  import cfpf_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              write_ready,
  output logic                   write_clock,
  output logic                   write_enable_n,
  output logic      [DATA_W-1:0] data_in,
  output logic                   read_clock,
  output logic                   read_enable_n
);
  initial begin
    write_clock    = 1'b0;
    write_enable_n = 1'b1;
    data_in        = 9'h1FF;
    read_clock     = 1'b0;
    read_enable_n  = 1'b1;
  end

  // Write edge, optionally waiting for buffer room
  task automatic wr(input logic [DATA_W-1:0] d, input logic en, input logic rdy);
    int n;
    n = 0;
    while (rdy && write_ready !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    write_clock    = 1'b1;
    write_enable_n = ~en;
    data_in        = d;
    @(negedge core_clk);
    write_clock    = 1'b0;
    write_enable_n = 1'b1;
    data_in        = ~d;
    repeat (2) @(negedge core_clk);
  endtask : wr

  // Read edge, enabled or flag update only
  task automatic rd(input logic en);
    @(negedge core_clk);
    read_clock    = 1'b1;
    read_enable_n = ~en;
    @(negedge core_clk);
    read_clock    = 1'b0;
    read_enable_n = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask : rd
endmodule : cfpf_partner

// *** cfpf_pkg.sv ***
package cfpf_pkg;
  // ********************************
  // Widths
  // ********************************
  localparam int DATA_W        = 9;
  localparam int CNT_W         = 13;
  localparam int P_W           = 6;
  localparam int P_SHIFT       = 4;
  localparam int PAR_LSB       = 6;
  localparam int PAR_W         = 3;
  localparam int PAR_BIT       = 8;
  localparam int BYTE_W        = 8;
  // ********************************
  // Depths
  // ********************************
  localparam int DEPTH_DEFAULT = 4096;
  localparam int DEPTH_SMALL   = 512;
  localparam logic [P_W-1:0] P_MASK_SMALL = 6'h0F;
  localparam logic [P_W-1:0] P_MASK_LARGE = 6'h3F;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  // ********************************
  // Reset values
  // ********************************
  localparam logic [DATA_W-1:0] PROG_DEFAULT = 9'h001;
  localparam logic [DATA_W-1:0] Q_RESET      = 9'h000;
  // ********************************
  // Parity modes
  // ********************************
  localparam logic [PAR_W-1:0] PAR_OFF      = 3'h0;
  localparam logic [PAR_W-1:0] PAR_GEN_EVEN = 3'h1;
  localparam logic [PAR_W-1:0] PAR_GEN_ODD  = 3'h2;
  localparam logic [PAR_W-1:0] PAR_CHK_EVEN = 3'h3;
  localparam logic [PAR_W-1:0] PAR_CHK_ODD  = 3'h4;
endpackage : cfpf_pkg

// *** cfpf_top.sv ***
`timescale 1ns/1ps
// What this block does
// [R1] Master reset shows empty flags, half high
// [R2] Reset release drives data outputs low
// [R3] Producer idles enables during reset unless programming
// [R4] Enabled write edge stores input word
// [R5] Enabled read edge presents next word
// [R6] Output enable high floats the data bus
// [R7] Cascaded: only read-enabled device drives bus
// [R8] Writes ignored while full
// [R9] Reads ignored when empty, output held
// [R10] Reset plus write enable loads programming word
// [R11] Reset plus read enable reads programming word
// [R12] Unprogrammed read returns default programming value
// [R13] Almost thresholds sit sixteen times P away
// [R14] Default P equals one
// [R15] Almost flag meaningless when cascaded
// [R16] High programming bits select parity mode
// [R17] Even check flags odd ones count
// [R18] Write past half asserts half-full flag
// [R19] Idle write edge refreshes fullness flags
// [R20] Half-full clears only after count drops
// [R21] Later opposite edge counted next update
// [R22] Full-looking queue ignores write
// [R23] P range depends on depth
// [R24] Emptiness on read edge, fullness on write
// [R25] Three flag pins encode six states
// [R26] Retransmit flags valid after recovery edges
// [R27] Depth is build parameter with derived thresholds
module cfpf_top
  import cfpf_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEFAULT
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic              write_clock,
  input  wire logic              read_clock,
  input  wire logic              write_enable_n,
  input  wire logic              read_enable_n,
  input  wire logic              master_reset_n,
  input  wire logic              output_enable_n,
  input  wire logic              cascade_mode,
  input  wire logic              first_load_retransmit,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_out_en_n,
  output logic                   full_empty_n,
  output logic                   almost_flag_n,
  output logic                   half_full_flag_n,
  output logic                   parity_indicator,
  output logic                   write_ready
);

  localparam int ADDR_W = $clog2(DEPTH);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] HALF_C  = CNT_W'(DEPTH / 2);

  // ********************************
  // Threshold decode
  // ********************************
  function automatic logic [CNT_W-1:0] p_words(input logic [P_W-1:0] p);
    logic [P_W-1:0] pm;
    pm = (DEPTH == DEPTH_SMALL) ? (p & P_MASK_SMALL) : (p & P_MASK_LARGE); // [R23]
    p_words = CNT_W'(pm) << P_SHIFT; // [R13] [R27]
  endfunction : p_words

  function automatic logic odd_ones(input logic [DATA_W-1:0] w);
    odd_ones = ^w[BYTE_W-1:0];
  endfunction : odd_ones

  logic              wclk_d;
  logic              rclk_d;
  logic              mr_n_d;
  logic [DATA_W-1:0] prog;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] wr_ptr;
  logic [ADDR_W-1:0] rd_ptr;
  logic [CNT_W-1:0]  mem_cnt;
  logic [DATA_W-1:0] buf_data [2];
  logic              buf_wp;
  logic              buf_rp;
  logic [1:0]        buf_cnt;
  logic              empty_st;
  logic              ae_st;
  logic              full_st;
  logic              af_st;
  logic              half_st;

  logic              w_edge;
  logic              r_edge;
  logic              mr_rise;
  logic              mr_fall;
  logic              prog_wr;
  logic              prog_rd;
  logic              rt_req;
  logic              buf_in_ready;
  logic              wr_accept;
  logic              rd_accept;
  logic              drain;
  logic [PAR_W-1:0]  par_mode;
  logic [DATA_W-1:0] wr_word;
  logic [CNT_W-1:0]  total;
  logic [CNT_W-1:0]  wflag_cnt;
  logic [CNT_W-1:0]  rflag_cnt;
  logic [CNT_W-1:0]  ae_thr;
  logic [CNT_W-1:0]  af_thr;
  logic [1:0]        next_buf_cnt;

  // ********************************
  // Edge and strobe decode
  // ********************************
  assign w_edge   = write_clock & ~wclk_d;
  assign r_edge   = read_clock & ~rclk_d;
  assign mr_rise  = master_reset_n & ~mr_n_d;
  assign mr_fall  = ~master_reset_n & mr_n_d;
  assign prog_wr  = w_edge & ~master_reset_n & ~write_enable_n; // [R10]
  assign prog_rd  = r_edge & ~master_reset_n & ~read_enable_n; // [R11]
  assign rt_req   = master_reset_n & ~cascade_mode & ~first_load_retransmit
                  & write_enable_n & read_enable_n;
  assign buf_in_ready = (buf_cnt != BUF_DEPTH);
  assign wr_accept = w_edge & master_reset_n & ~write_enable_n
                   & ~full_st & buf_in_ready; // [R4] [R8] [R22]
  assign rd_accept = r_edge & master_reset_n & ~read_enable_n
                   & ~empty_st & (mem_cnt != '0); // [R5] [R9]
  assign drain    = (buf_cnt != 2'h0) & (mem_cnt != DEPTH_C) & master_reset_n;
  assign par_mode = prog[PAR_LSB +: PAR_W];

  always_comb begin
    wr_word = data_in;
    if (par_mode == PAR_GEN_EVEN) begin // [R16]
      wr_word[PAR_BIT] = odd_ones(data_in);
    end else if (par_mode == PAR_GEN_ODD) begin
      wr_word[PAR_BIT] = ~odd_ones(data_in);
    end
  end

  assign total     = mem_cnt + CNT_W'(buf_cnt);
  assign wflag_cnt = total + CNT_W'(wr_accept); // [R21]
  assign rflag_cnt = total - CNT_W'(rd_accept); // [R21]
  assign ae_thr    = p_words(prog[P_W-1:0]);
  assign af_thr    = DEPTH_C - ae_thr;
  assign next_buf_cnt = buf_cnt + 2'(wr_accept) - 2'(drain);

  // ********************************
  // Edge history
  // ********************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
      mr_n_d <= 1'b1;
    end else if (clk_en) begin
      wclk_d <= write_clock;
      rclk_d <= read_clock;
      mr_n_d <= master_reset_n;
    end
  end

  // ********************************
  // Programming register
  // ********************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prog <= PROG_DEFAULT; // [R14]
    end else if (clk_en) begin
      if (prog_wr) begin
        prog <= data_in; // [R10]
      end else if (mr_fall) begin
        prog <= PROG_DEFAULT; // [R12] [R14]
      end
    end
  end

  // ********************************
  // Two-entry input buffer
  // ********************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      buf_wp  <= 1'b0;
      buf_rp  <= 1'b0;
      buf_cnt <= 2'h0;
    end else if (clk_en) begin
      if (!master_reset_n) begin
        buf_wp  <= 1'b0;
        buf_rp  <= 1'b0;
        buf_cnt <= 2'h0;
      end else begin
        if (wr_accept) begin
          buf_wp <= ~buf_wp;
        end
        if (drain) begin
          buf_rp <= ~buf_rp;
        end
        buf_cnt <= next_buf_cnt;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en && wr_accept) begin
      buf_data[buf_wp] <= wr_word; // [R4]
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      write_ready <= 1'b0;
    end else if (clk_en) begin
      write_ready <= master_reset_n & (next_buf_cnt != BUF_DEPTH);
    end
  end

  // ********************************
  // Storage array
  // ********************************
  always_ff @(posedge core_clk) begin
    if (clk_en && drain) begin
      mem[wr_ptr] <= buf_data[buf_rp];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      mem_cnt <= '0;
    end else if (clk_en) begin
      if (!master_reset_n) begin
        wr_ptr  <= '0; // [R1]
        rd_ptr  <= '0;
        mem_cnt <= '0;
      end else if (rt_req) begin
        rd_ptr  <= '0; // [R26]
        mem_cnt <= CNT_W'(wr_ptr);
      end else begin
        if (drain) begin
          wr_ptr <= wr_ptr + 1'b1;
        end
        if (rd_accept) begin
          rd_ptr <= rd_ptr + 1'b1;
        end
        mem_cnt <= mem_cnt + CNT_W'(drain) - CNT_W'(rd_accept);
      end
    end
  end

  // ********************************
  // Data output register
  // ********************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_out <= Q_RESET;
    end else if (clk_en) begin
      if (mr_rise) begin
        data_out <= Q_RESET; // [R2]
      end else if (prog_rd) begin
        data_out <= prog; // [R11] [R12]
      end else if (rd_accept) begin
        data_out <= mem[rd_ptr]; // [R5] [R9]
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      parity_indicator <= 1'b0;
    end else if (clk_en) begin
      if (!master_reset_n) begin
        parity_indicator <= 1'b0;
      end else if (rd_accept) begin
        if (par_mode == PAR_CHK_EVEN) begin
          parity_indicator <= odd_ones(mem[rd_ptr]); // [R17]
        end else if (par_mode == PAR_CHK_ODD) begin
          parity_indicator <= ~odd_ones(mem[rd_ptr]); // [R16]
        end else begin
          parity_indicator <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_out_en_n <= 1'b1;
    end else if (clk_en) begin
      data_out_en_n <= output_enable_n | (cascade_mode & read_enable_n); // [R6] [R7]
    end
  end

  // ********************************
  // Emptiness flags on read edges
  // ********************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      empty_st <= 1'b1;
      ae_st    <= 1'b1;
    end else if (clk_en) begin
      if (!master_reset_n) begin
        empty_st <= 1'b1; // [R1]
        ae_st    <= 1'b1;
      end else if (r_edge) begin
        empty_st <= (rflag_cnt == '0); // [R24]
        ae_st    <= (rflag_cnt <= ae_thr); // [R13]
      end
    end
  end

  // ********************************
  // Fullness flags on write edges
  // ********************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      full_st <= 1'b0;
      af_st   <= 1'b0;
      half_st <= 1'b0;
    end else if (clk_en) begin
      if (!master_reset_n) begin
        full_st <= 1'b0; // [R1]
        af_st   <= 1'b0;
        half_st <= 1'b0;
      end else if (w_edge) begin
        full_st <= (wflag_cnt == DEPTH_C); // [R19] [R24]
        af_st   <= (wflag_cnt >= af_thr); // [R13]
        half_st <= (wflag_cnt > HALF_C); // [R18] [R20]
      end
    end
  end

  // ********************************
  // Flag pins
  // ********************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      full_empty_n     <= 1'b0;
      almost_flag_n    <= 1'b0;
      half_full_flag_n <= 1'b1;
    end else if (clk_en) begin
      full_empty_n     <= ~(empty_st | full_st); // [R25]
      almost_flag_n    <= cascade_mode | ~(ae_st | af_st); // [R15] [R25]
      half_full_flag_n <= ~half_st; // [R25]
    end
  end

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset || !clk_en);

  sequence s_rd_update;
    r_edge && master_reset_n && (rflag_cnt != '0) && !full_st;
  endsequence

  sequence s_flag_shown;
    !empty_st ##1 (full_empty_n || full_st);
  endsequence

  a_mr_empty_flags: assert property (
    !master_reset_n ##1 !master_reset_n |=> !full_empty_n && half_full_flag_n) // [R1]
    else $error("reset flags wrong");
  a_mr_rise_zero: assert property (mr_rise |=> data_out == Q_RESET) // [R2]
    else $error("data not zero after reset release");
  a_full_blocks: assert property (w_edge && full_st && master_reset_n |=> $stable(buf_wp)) // [R8]
    else $error("write taken while full");
  a_empty_hold: assert property (
    r_edge && empty_st && master_reset_n && !mr_rise |=> $stable(data_out)) // [R9]
    else $error("output changed on empty read");
  a_prog_load: assert property (prog_wr |=> prog == $past(data_in)) // [R10]
    else $error("program write lost");
  a_prog_read: assert property (prog_rd |=> data_out == $past(prog)) // [R11]
    else $error("program read wrong");
  a_oe_float: assert property (output_enable_n |=> data_out_en_n) // [R6]
    else $error("bus driven without enable");
  a_cascade_drive: assert property (cascade_mode && read_enable_n |=> data_out_en_n) // [R7]
    else $error("cascaded device drove bus");
  a_half_flag: assert property (
    w_edge && master_reset_n && (wflag_cnt > HALF_C) |=> ##1 !half_full_flag_n) // [R18]
    else $error("half flag missed");
  a_latent_update: assert property (s_rd_update |=> s_flag_shown) // [R24]
    else $error("empty flag not updated");
  a_parity_even: assert property (
    rd_accept && (par_mode == PAR_CHK_EVEN)
    |=> parity_indicator == ^data_out[BYTE_W-1:0]) // [R17]
    else $error("parity indicator wrong");

endmodule : cfpf_top

// *** test_cfpf_top.sv ***
`timescale 1ns/1ps
module test_cfpf_top
  import cfpf_pkg::*;
;
  typedef struct packed {
    logic [DATA_W-1:0] prog;
    logic [DATA_W-1:0] din;
    logic [DATA_W-1:0] dout;
    logic              par;
  } cfpf_row_t;
  // ****
  // Ordinary cases: parity modes
  // ****
  cfpf_row_t rows [0:5] = '{
    '{9'h001, 9'h1F3, 9'h1F3, 1'b0},
    '{9'h041, 9'h007, 9'h107, 1'b0},
    '{9'h081, 9'h003, 9'h103, 1'b0},
    '{9'h0C1, 9'h00B, 9'h00B, 1'b1},
    '{9'h101, 9'h00B, 9'h00B, 1'b0},
    '{9'h0C1, 9'h003, 9'h003, 1'b0}};
  logic              core_clk = 1'b0;
  logic              reset;
  logic              write_clock;
  logic              read_clock;
  logic              write_enable_n;
  logic              read_enable_n;
  logic              master_reset_n;
  logic              output_enable_n;
  logic              cascade_mode;
  logic              clk_en;
  logic              first_load_retransmit;
  logic [DATA_W-1:0] data_in;
  logic [DATA_W-1:0] data_out;
  logic              data_out_en_n;
  logic              full_empty_n;
  logic              almost_flag_n;
  logic              half_full_flag_n;
  logic              parity_indicator;
  logic              write_ready;
  int                err_total = 0;
  int                compares  = 0;

  always #2.5 core_clk = ~core_clk;

  cfpf_top #(.DEPTH(DEPTH_SMALL)) cfpf_top_i (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .write_clock(write_clock), .read_clock(read_clock),
    .write_enable_n(write_enable_n), .read_enable_n(read_enable_n),
    .master_reset_n(master_reset_n), .output_enable_n(output_enable_n),
    .cascade_mode(cascade_mode), .first_load_retransmit(first_load_retransmit),
    .data_in(data_in), .data_out(data_out), .data_out_en_n(data_out_en_n),
    .full_empty_n(full_empty_n), .almost_flag_n(almost_flag_n),
    .half_full_flag_n(half_full_flag_n), .parity_indicator(parity_indicator),
    .write_ready(write_ready));

  cfpf_partner cfpf_partner_i (
    .core_clk(core_clk), .write_ready(write_ready),
    .write_clock(write_clock), .write_enable_n(write_enable_n),
    .data_in(data_in), .read_clock(read_clock), .read_enable_n(read_enable_n));

  task automatic chk_word(input string nm, input logic [DATA_W-1:0] want,
                          input logic [DATA_W-1:0] got);
    compares++;
    if (got !== want) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, want, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic want, input logic got);
    compares++;
    if (got !== want) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", nm, want, got);
    end
  endtask : chk_bit

  task automatic summarize();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // Master reset cycle with program read
  task automatic mrst(input logic [DATA_W-1:0] prog, input logic do_prog);
    @(negedge core_clk);
    master_reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    if (do_prog) cfpf_partner_i.wr(prog, 1'b1, 1'b0);
    cfpf_partner_i.rd(1'b1);
    chk_word("prog_read", do_prog ? prog : PROG_DEFAULT, data_out);
    chk_bit("mr_fe", 1'b0, full_empty_n);
    chk_bit("mr_hf", 1'b1, half_full_flag_n);
    chk_bit("mr_rdy", 1'b0, write_ready);
    master_reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk_word("release_q", Q_RESET, data_out);
    chk_bit("rel_rdy", 1'b1, write_ready);
  endtask : mrst

  initial begin
    #100000;
    err_total++;
    summarize();
  end

  initial begin
    int                m;
    logic [DATA_W-1:0] want;
    reset           = 1'b1;
    master_reset_n  = 1'b1;
    output_enable_n = 1'b0;
    cascade_mode    = 1'b0;
    clk_en          = 1'b1;
    first_load_retransmit = 1'b1;
    repeat (12) @(negedge core_clk);
    chk_bit("rst_fe", 1'b0, full_empty_n);
    chk_bit("rst_af", 1'b0, almost_flag_n);
    chk_bit("rst_hf", 1'b1, half_full_flag_n);
    chk_word("rst_q", Q_RESET, data_out);
    reset = 1'b0;
    repeat (2) @(negedge core_clk);
    foreach (rows[i]) begin
      mrst(rows[i].prog, i != 0);
      cfpf_partner_i.wr(rows[i].din, 1'b1, 1'b1);
      cfpf_partner_i.rd(1'b0);
      cfpf_partner_i.rd(1'b1);
      chk_word("row_q", rows[i].dout, data_out);
      chk_bit("row_pg", rows[i].par, parity_indicator);
    end
    // ****
    // Fill past full with P of two
    // ****
    mrst(9'h0C2, 1'b1);
    for (int n = 1; n <= 513; n++) begin
      want = (n > 512) ? 9'h1AA : n[8:0] - 9'h001;
      cfpf_partner_i.wr(want, 1'b1, 1'b1);
      cfpf_partner_i.rd(1'b0);
      m = (n > 512) ? 512 : n;
      chk_bit("fill_fe", m != 512, full_empty_n);
      chk_bit("fill_af", !(m <= 32 || m >= 480), almost_flag_n);
      chk_bit("fill_hf", !(m > 256), half_full_flag_n);
    end
    cfpf_partner_i.rd(1'b1);
    chk_word("first_q", 9'h000, data_out);
    cfpf_partner_i.wr(9'h155, 1'b1, 1'b1);
    chk_bit("stale_fe", 1'b1, full_empty_n);
    cfpf_partner_i.wr(9'h0AB, 1'b1, 1'b1);
    chk_bit("refull_fe", 1'b0, full_empty_n);
    for (int k = 1; k <= 512; k++) begin
      want = (k == 512) ? 9'h0AB : k[8:0];
      cfpf_partner_i.rd(1'b1);
      chk_word("drain_q", want, data_out);
      chk_bit("drain_pg", ^want[7:0], parity_indicator);
    end
    cfpf_partner_i.rd(1'b1);
    chk_word("empty_q", 9'h0AB, data_out);
    chk_bit("empty_fe", 1'b0, full_empty_n);
    chk_bit("stale_hf", 1'b0, half_full_flag_n);
    cfpf_partner_i.wr(9'h000, 1'b0, 1'b1);
    chk_bit("upd_hf", 1'b1, half_full_flag_n);
    // ****
    // Output enable and cascade
    // ****
    for (int j = 0; j < 4; j++) begin
      @(negedge core_clk);
      output_enable_n = j[0];
      cascade_mode    = j[1];
      repeat (2) @(negedge core_clk);
      chk_bit("oe_n", j[0] | j[1], data_out_en_n);
      chk_bit("cas_af", j[1], almost_flag_n);
    end
    // ****
    // Clock enable freeze and retransmit
    // ****
    @(negedge core_clk);
    output_enable_n = 1'b0;
    cascade_mode    = 1'b0;
    mrst(9'h000, 1'b0);
    clk_en = 1'b0;
    cfpf_partner_i.wr(9'h123, 1'b1, 1'b0);
    clk_en = 1'b1;
    cfpf_partner_i.rd(1'b0);
    chk_bit("frz_fe", 1'b0, full_empty_n);
    cfpf_partner_i.wr(9'h011, 1'b1, 1'b1);
    cfpf_partner_i.wr(9'h022, 1'b1, 1'b1);
    cfpf_partner_i.rd(1'b0);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) begin
        first_load_retransmit = 1'b0;
        repeat (2) @(negedge core_clk);
        first_load_retransmit = 1'b1;
        cfpf_partner_i.rd(1'b0);
      end
      cfpf_partner_i.rd(1'b1);
      chk_word("rt_q", k[0] ? 9'h022 : 9'h011, data_out);
    end
    summarize();
  end
endmodule : test_cfpf_top
